// *** hw/rcpd_decoder.sv ***
`timescale 1ns/1ps
`include "rcpd_defines.svh"
// What this block does
// - Check packet address against local address first
// - On address match store packet, compare next
// - Two matching packets drive outputs, raise valid
// - Mismatch or timing error clears outputs, sleeps
// - Changed data pair forces outputs low briefly
// - Address inputs pulled up, floating reads high
// - Foreign address packet has no effect
// - Eight outputs mirror transmitter data inputs
// - Raw demodulated stream on own output, held low in power-down
// - Data select high: high one, low zero
// - Data select low: low is open, outputs low
// - Address select pair picks one/zero/open meaning
// - Data select defaults low by pull-down
// - Address select defaults: high pulled up, low down
// - Both ends must share type settings
// - Power-down low stops all reception
module rcpd_decoder #(
    parameter int CNT_W    = 24,
    parameter int UNIT_CYC = `RCPD_UNIT_CYC,
    parameter int HOLD_CYC = `RCPD_HOLD_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Demodulated line and power control
    input  wire logic       rf_data_in,
    input  wire logic       power_down_n,
    // Straps (pads carry the pulls)
    input  wire logic [9:0] address_select_inputs,
    input  wire logic       address_type_select_low,
    input  wire logic       address_type_select_high,
    input  wire logic       data_type_select,
    // Decoded results
    output logic      [7:0] decoded_outputs,
    output logic            valid_flag,
    output logic            raw_data_out
);

    // High-time decision points sit midway between nominal pulse lengths, half a unit of slack each way; LOW_MAX allows a full unit
    localparam logic [CNT_W-1:0] HIGH_MIN = CNT_W'(UNIT_CYC / 2);
    localparam logic [CNT_W-1:0] DECIDE   = CNT_W'((UNIT_CYC * 3) / 2);
    localparam logic [CNT_W-1:0] HIGH_MAX = CNT_W'((UNIT_CYC * 5) / 2);
    localparam logic [CNT_W-1:0] LOW_MAX  = CNT_W'(UNIT_CYC * 3);
    localparam logic [CNT_W-1:0] GAP_MIN  = CNT_W'(UNIT_CYC * 4);
    localparam logic [CNT_W-1:0] HOLD_MAX = CNT_W'(HOLD_CYC);
    localparam int               NB       = `RCPD_PKT_BITS;

    // Local symbol for one address level under the address type select
    function automatic rcpd_pkg::rcpd_sym_t addr_sym(input logic lvl, input logic [1:0] cfg);
        if (lvl)
            return (cfg == `RCPD_ACFG_OPEN_ZERO) ? `RCPD_SYM_OPEN : `RCPD_SYM_ONE;
        else
            return (cfg == `RCPD_ACFG_ONE_OPEN) ? `RCPD_SYM_OPEN : `RCPD_SYM_ZERO;
    endfunction : addr_sym

    // A data symbol is legal only if the local data type could produce it
    function automatic logic data_legal(input rcpd_pkg::rcpd_sym_t s, input logic dcfg);
        return (s == `RCPD_SYM_ONE) || (s == (dcfg ? `RCPD_SYM_ZERO : `RCPD_SYM_OPEN));
    endfunction : data_legal

    // Two-flop synchronisers for every pin input
    // Straps take the same two flops as the line, so a strap change needs two cycles to apply
    logic [14:0] in_meta_reg;
    logic [14:0] in_sync_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_meta_reg <= 15'h0000;
            in_sync_reg <= 15'h0000;
        end else begin
            in_meta_reg <= {rf_data_in, power_down_n, address_select_inputs,
                            address_type_select_high, address_type_select_low, data_type_select};
            in_sync_reg <= in_meta_reg;
        end
    end

    logic       rx;
    logic       pdn_ok;
    logic [9:0] addr_lvl;
    logic [1:0] acfg;
    logic       dcfg;

    // Unconnected pads read high on the address pins, pull defaults on the selects
    assign rx       = in_sync_reg[14];
    assign pdn_ok   = in_sync_reg[13];
    assign addr_lvl = in_sync_reg[12:3];
    assign acfg     = in_sync_reg[2:1];
    assign dcfg     = in_sync_reg[0];

    // Raw stream bypasses the decoder; the receiver is dead in power-down
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            raw_data_out <= 1'b0;
        else
            raw_data_out <= rx & pdn_ok;
    end

    // Line receiver
    rcpd_pkg::rcpd_state_t state_reg;
    logic [CNT_W-1:0]      cnt_reg;
    logic [5:0]            nbits_reg;
    logic [NB-2:0]         shift_reg;

    logic          fall;
    logic          bit_take;
    logic          bit_val;
    logic          timing_err;
    logic          pkt_done;
    logic [NB-1:0] pkt;

    assign fall       = (state_reg == rcpd_pkg::RCPD_ST_HIGH) && !rx;
    assign bit_take   = pdn_ok && fall && (cnt_reg >= HIGH_MIN);
    assign bit_val    = cnt_reg >= DECIDE;
    // Bounded high and low times are what reject noise between packets
    assign timing_err = pdn_ok &&
                        (((state_reg == rcpd_pkg::RCPD_ST_HIGH) && rx && (cnt_reg >= HIGH_MAX)) ||
                         (fall && (cnt_reg < HIGH_MIN)) ||
                         ((state_reg == rcpd_pkg::RCPD_ST_LOW) && !rx && (cnt_reg >= LOW_MAX)));
    assign pkt_done   = bit_take && (nbits_reg == 6'(NB - 1));
    assign pkt        = {shift_reg, bit_val};

    // Receiver state: sleep through the gap, then follow pulse highs and lows
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= rcpd_pkg::RCPD_ST_GAP;
        end else if (!pdn_ok) begin
            state_reg <= rcpd_pkg::RCPD_ST_GAP;
        end else begin
            case (state_reg)
                rcpd_pkg::RCPD_ST_GAP: begin
                    // Sleep until the line has been quiet long enough to frame a packet
                    if (!rx && cnt_reg >= GAP_MIN - 1'b1)
                        state_reg <= rcpd_pkg::RCPD_ST_READY;
                end
                rcpd_pkg::RCPD_ST_READY: begin
                    // First rising edge after the gap starts bit 0
                    if (rx)
                        state_reg <= rcpd_pkg::RCPD_ST_HIGH;
                end
                rcpd_pkg::RCPD_ST_HIGH: begin
                    if (timing_err || pkt_done)
                        state_reg <= rcpd_pkg::RCPD_ST_GAP;
                    else if (!rx)
                        state_reg <= rcpd_pkg::RCPD_ST_LOW;
                end
                rcpd_pkg::RCPD_ST_LOW: begin
                    if (timing_err)
                        state_reg <= rcpd_pkg::RCPD_ST_GAP;
                    else if (rx)
                        state_reg <= rcpd_pkg::RCPD_ST_HIGH;
                end
                default: begin
                    state_reg <= rcpd_pkg::RCPD_ST_GAP;
                end
            endcase
        end
    end

    // Pulse and gap timer, restarted at every line edge; it saturates in the gap so a long idle cannot wrap
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (!pdn_ok) begin
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                rcpd_pkg::RCPD_ST_GAP: begin
                    cnt_reg <= rx ? '0 : ((cnt_reg == '1) ? cnt_reg : cnt_reg + 1'b1);
                end
                rcpd_pkg::RCPD_ST_READY: begin
                    cnt_reg <= CNT_W'(1);
                end
                rcpd_pkg::RCPD_ST_HIGH: begin
                    if (timing_err || pkt_done)
                        cnt_reg <= '0;
                    else if (rx)
                        cnt_reg <= cnt_reg + 1'b1;
                    else
                        cnt_reg <= CNT_W'(1);
                end
                rcpd_pkg::RCPD_ST_LOW: begin
                    if (timing_err)
                        cnt_reg <= '0;
                    else if (rx)
                        cnt_reg <= CNT_W'(1);
                    else
                        cnt_reg <= cnt_reg + 1'b1;
                end
                default: begin
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // Bits taken so far in the current packet
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            nbits_reg <= 6'h00;
        else if (!pdn_ok || state_reg == rcpd_pkg::RCPD_ST_READY)
            nbits_reg <= 6'h00;
        else if (bit_take && !pkt_done)
            nbits_reg <= nbits_reg + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            shift_reg <= '0;
        else if (bit_take)
            shift_reg <= pkt[NB-2:0];
    end

    // Packet checks: address symbols first, then data symbols, upper symbol bit first
    logic        addr_ok;
    logic        data_ok;
    logic        pkt_ok;
    logic [15:0] pkt_data;

    always_comb begin
        addr_ok = 1'b1;
        data_ok = 1'b1;
        for (int i = 0; i < `RCPD_ADDR_SYMS; i++) begin
            if (pkt[NB-1-2*i -: 2] != addr_sym(addr_lvl[i], acfg))
                addr_ok = 1'b0;
        end
        for (int j = 0; j < `RCPD_DATA_SYMS; j++) begin
            if (!data_legal(pkt[15-2*j -: 2], dcfg))
                data_ok = 1'b0;
        end
    end

    assign pkt_data = pkt[15:0];
    // A foreign address is dropped here and touches nothing downstream
    assign pkt_ok   = pkt_done && addr_ok && data_ok;

    // Pairing and outputs
    logic [15:0]      first_reg;
    logic             have_first_reg;
    logic [CNT_W-1:0] hold_cnt_reg;
    logic [7:0]       dec_next;
    logic             pair_match;
    logic             hold_expired;

    // Open and zero symbols both leave the output low
    always_comb begin
        for (int k = 0; k < `RCPD_DATA_SYMS; k++)
            dec_next[k] = (pkt_data[15-2*k -: 2] == `RCPD_SYM_ONE);
    end

    assign pair_match   = have_first_reg && (pkt_data == first_reg);
    assign hold_expired = valid_flag && !pkt_ok && (hold_cnt_reg >= HOLD_MAX - 1'b1);

    // A mismatching packet still becomes the new reference, so its next copy can publish
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            first_reg      <= 16'h0000;
            have_first_reg <= 1'b0;
        end else if (!pdn_ok || timing_err || hold_expired) begin
            have_first_reg <= 1'b0;
        end else if (pkt_ok) begin
            first_reg      <= pkt_data;
            have_first_reg <= 1'b1;
        end
    end

    // Decoded outputs and valid flag, registered
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            decoded_outputs <= 8'h00;
            valid_flag      <= 1'b0;
        end else if (!pdn_ok || timing_err) begin
            decoded_outputs <= 8'h00;
            valid_flag      <= 1'b0;
        end else if (pkt_ok && pair_match) begin
            decoded_outputs <= dec_next;
            valid_flag      <= 1'b1;
        end else if (pkt_ok && have_first_reg) begin
            decoded_outputs <= 8'h00;
            valid_flag      <= 1'b0;
        end else if (hold_expired) begin
            // Valid packets stopped: drop everything and wait for a fresh pair
            decoded_outputs <= 8'h00;
            valid_flag      <= 1'b0;
        end
    end

    // Runs only while valid is up; each accepted packet restarts it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            hold_cnt_reg <= '0;
        else if (!valid_flag || pkt_ok)
            hold_cnt_reg <= '0;
        else
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end

endmodule : rcpd_decoder

// *** hw/rcpd_defines.svh ***
`ifndef RCPD_DEFINES_SVH
`define RCPD_DEFINES_SVH

// Clock rate and line-code time unit
`define RCPD_CLK_MHZ      25
`define RCPD_UNIT_US      100
`define RCPD_UNIT_CYC     (`RCPD_UNIT_US * `RCPD_CLK_MHZ)
// Idle hold before valid_flag drops when no matching packet arrives
`define RCPD_HOLD_MS      50
`define RCPD_HOLD_CYC     (`RCPD_HOLD_MS * 1000 * `RCPD_CLK_MHZ)

// Packet layout: 10 address symbols then 8 data symbols, 2 line bits each
`define RCPD_ADDR_SYMS    10
`define RCPD_DATA_SYMS    8
`define RCPD_PKT_BITS     36

// Symbol codes on the line
`define RCPD_SYM_ZERO     2'h0
`define RCPD_SYM_OPEN     2'h1
`define RCPD_SYM_ONE      2'h3

// Address type select codes {high, low}
`define RCPD_ACFG_ONE_OPEN  2'h1
`define RCPD_ACFG_OPEN_ZERO 2'h2

`endif

// *** hw/rcpd_pkg.sv ***
package rcpd_pkg;

    typedef enum logic [1:0] {
        RCPD_ST_GAP   = 2'b00,
        RCPD_ST_READY = 2'b01,
        RCPD_ST_HIGH  = 2'b10,
        RCPD_ST_LOW   = 2'b11
    } rcpd_state_t;

    typedef logic [1:0] rcpd_sym_t;

endpackage : rcpd_pkg

// *** tb/rcpd_decoder_props.sv ***
`timescale 1ns/1ps
module rcpd_decoder_props #(
    parameter int HOLD_CYC = 2000
) (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       rf_data_in,
    input wire logic       power_down_n,
    input wire logic [9:0] address_select_inputs,
    input wire logic       address_type_select_low,
    input wire logic       address_type_select_high,
    input wire logic       data_type_select,
    input wire logic [7:0] decoded_outputs,
    input wire logic       valid_flag,
    input wire logic       raw_data_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [3:0]  up_cnt_reg;
    logic [31:0] idle_cnt_reg;

    // Raw path only comparable once sync flops have flushed
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) up_cnt_reg <= 4'h0;
        else if (!power_down_n) up_cnt_reg <= 4'h0;
        else if (up_cnt_reg != 4'hF) up_cnt_reg <= up_cnt_reg + 4'h1;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) idle_cnt_reg <= 32'h0;
        else if (!valid_flag || rf_data_in) idle_cnt_reg <= 32'h0;
        else idle_cnt_reg <= idle_cnt_reg + 32'h1;
    end

    a_valid_data_tie:   assert property (!valid_flag |-> decoded_outputs == 8'h00)
        else $error("outputs nonzero while valid low");
    a_raw_follows_line: assert property (up_cnt_reg >= 4'h6 |-> raw_data_out == $past(rf_data_in, 3))
        else $error("raw output does not follow line");
    a_pd_clears_out:    assert property (!power_down_n [*4] |-> !valid_flag && decoded_outputs == 8'h00)
        else $error("outputs alive in power-down");
    a_pd_raw_low:       assert property (!power_down_n [*4] |-> !raw_data_out)
        else $error("raw output alive in power-down");
    a_valid_after_fall: assert property ($rose(valid_flag) |-> !$past(rf_data_in, 2))
        else $error("valid rose inside a pulse");
    a_out_change_valid: assert property ($changed(decoded_outputs) |-> $changed(valid_flag))
        else $error("outputs changed without valid change");
    a_hold_bound:       assert property (idle_cnt_reg <= HOLD_CYC + 16)
        else $error("valid held past hold time");
    a_rise_powered:     assert property ($rose(valid_flag) |-> $past(power_down_n, 3))
        else $error("valid rose while powered down");

    c_valid_set:  cover property ($rose(valid_flag));
    c_valid_drop: cover property ($fell(valid_flag) && power_down_n);
    c_power_down: cover property (!power_down_n [*4]);
endmodule : rcpd_decoder_props

bind rcpd_decoder rcpd_decoder_props #(.HOLD_CYC(HOLD_CYC)) u_props (.clk_sys(clk_sys), .arst_n(arst_n),
    .rf_data_in(rf_data_in), .power_down_n(power_down_n), .address_select_inputs(address_select_inputs),
    .address_type_select_low(address_type_select_low), .address_type_select_high(address_type_select_high),
    .data_type_select(data_type_select), .decoded_outputs(decoded_outputs), .valid_flag(valid_flag),
    .raw_data_out(raw_data_out));

// *** tb/rcpd_encoder_model.sv ***
`timescale 1ns/1ps
`include "rcpd_defines.svh"
module rcpd_encoder_model #(
    parameter int UNIT_CYC = 8
) (
    // Clock and demodulated line
    input  wire logic clk_sys,
    output logic      rf_line
);
    initial rf_line = 1'b0;

    task automatic hold_line(input logic lvl, input int units);
        rf_line = lvl;
        repeat (units * UNIT_CYC) @(negedge clk_sys);
    endtask : hold_line

    // Idle low doubles as the inter-packet gap, so the line never floats between frames
    task automatic send(input logic [9:0] addr, input logic [7:0] data, input logic ahi, input logic alo,
                        input logic dsel, input logic bad);
        logic [35:0] bits;
        for (int i = 0; i < 10; i++) begin
            bits[35-2*i -: 2] = addr[i] ? ((ahi && !alo) ? `RCPD_SYM_OPEN : `RCPD_SYM_ONE)
                                        : ((!ahi && alo) ? `RCPD_SYM_OPEN : `RCPD_SYM_ZERO);
        end
        for (int k = 0; k < 8; k++) begin
            bits[15-2*k -: 2] = data[k] ? `RCPD_SYM_ONE : (dsel ? `RCPD_SYM_ZERO : `RCPD_SYM_OPEN);
        end
        hold_line(1'b0, 5);
        if (bad) begin
            // Over-long first pulse, then silence
            hold_line(1'b1, 3);
        end else begin
            for (int b = 35; b >= 0; b--) begin
                hold_line(1'b1, bits[b] ? 2 : 1);
                hold_line(1'b0, bits[b] ? 1 : 2);
            end
        end
        hold_line(1'b0, 1);
    endtask : send
endmodule : rcpd_encoder_model

// *** tb/test_remote_control_packet_decoder.sv ***
`timescale 1ns/1ps
module test_remote_control_packet_decoder;
    logic       clk_sys;
    logic       arst_n;
    logic       power_down_n;
    logic       ahi;
    logic       alo;
    logic       dsel;
    logic [9:0] addr;
    logic [7:0] dout;
    logic       rf;
    logic       valid;
    logic       raw;
    logic [2:0] rf_hist;
    logic [2:0] pd_hist;
    logic [7:0] d;
    logic [7:0] ref_data;
    logic [7:0] exp_data;
    logic       have_ref;
    logic       exp_valid;
    int         fail_count;
    int         checks_done;
    int         seed;
    int         cyc;

    rcpd_decoder #(.UNIT_CYC(8), .HOLD_CYC(2000)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .rf_data_in(rf),
        .power_down_n(power_down_n), .address_select_inputs(addr), .address_type_select_low(alo),
        .address_type_select_high(ahi), .data_type_select(dsel), .decoded_outputs(dout), .valid_flag(valid),
        .raw_data_out(raw));
    rcpd_encoder_model #(.UNIT_CYC(8)) enc (.clk_sys(clk_sys), .rf_line(rf));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    always @(posedge clk_sys) begin
        cyc++;
        rf_hist <= {rf_hist[1:0], rf};
        pd_hist <= {pd_hist[1:0], power_down_n};
        if (cyc == 80000) begin
            fail_count++;
            conclude();
        end
    end

    // Raw line is the pin three edges late, forced low by power-down
    always @(negedge clk_sys) begin
        if (cyc > 6) begin
            checks_done++;
            if (raw !== (rf_hist[2] & pd_hist[2])) begin
                fail_count++;
                $display("ERROR raw_data_out expected %b seen %b", rf_hist[2] & pd_hist[2], raw);
            end
        end
    end

    task automatic check_out();
        checks_done++;
        if (valid !== exp_valid || dout !== exp_data) begin
            fail_count++;
            $display("ERROR outputs expected %h/%b seen %h/%b", exp_data, exp_valid, dout, valid);
        end
    endtask : check_out

    // Reference pairing: two identical accepted packets in a row publish the data
    task automatic pkt(input logic [7:0] pd, input logic match, input logic bad);
        enc.send(match ? addr : ~addr, pd, ahi, alo, dsel, bad);
        if (bad) begin
            exp_valid = 1'b0;
            exp_data = 8'h00;
            have_ref = 1'b0;
        end else if (match) begin
            exp_valid = have_ref && ref_data === pd;
            exp_data = exp_valid ? pd : 8'h00;
            ref_data = pd;
            have_ref = 1'b1;
        end
        check_out();
    endtask : pkt

    initial begin
        seed = 35521;
        fail_count = 0;
        checks_done = 0;
        cyc = 0;
        arst_n = 1'b0;
        power_down_n = 1'b1;
        {ahi, alo, dsel} = 3'h4;
        addr = 10'h2B5;
        have_ref = 1'b0;
        exp_valid = 1'b0;
        exp_data = 8'h00;
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        check_out();
        for (int c = 0; c < 8; c++) begin
            {ahi, alo, dsel} = 3'(c) ^ 3'h4;
            d = 8'($random(seed));
            pkt(d, 1'b1, 1'b0);
            pkt(d, 1'b1, 1'b0);
            pkt(~d, 1'b0, 1'b0);
            pkt(d ^ 8'h01, 1'b1, 1'b0);
            pkt(d ^ 8'h01, 1'b1, 1'b0);
            // Odd passes cut a published pair with a bad pulse, even passes with power-down
            if (c[0])
                pkt(d, 1'b1, 1'b1);
            power_down_n = 1'b0;
            repeat (6) @(negedge clk_sys);
            have_ref = 1'b0;
            exp_valid = 1'b0;
            exp_data = 8'h00;
            check_out();
            power_down_n = 1'b1;
            if (!c[0])
                pkt(d, 1'b1, 1'b1);
        end
        pkt(d, 1'b1, 1'b0);
        pkt(d, 1'b1, 1'b0);
        repeat (2100) @(negedge clk_sys);
        exp_valid = 1'b0;
        exp_data = 8'h00;
        check_out();
        conclude();
    end
endmodule : test_remote_control_packet_decoder
